// ---- strap_pkg.sv ----
// Purpose: Shared constants and carriers for the strap-based pin selection.
// Assumes: A 32-bit classic Wishbone register bus with byte addresses.
// Notes:   Every offset, field position and reset value is named here once.

package strap_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam int          CTRL_EN_LSB    = 0;
    localparam int          CTRL_DIR_LSB   = 8;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

    // Status bit positions.
    localparam int ST_CELL_SEL    = 0;
    localparam int ST_HOST_SEL    = 1;
    localparam int ST_SERIAL2_SEL = 2;
    localparam int ST_EEPROM_AUTOINIT_STRAP        = 3;
    localparam int ST_EE_LOAD     = 4;
    localparam int ST_SER3_EN     = 5;
    localparam int ST_EEPROM_EN   = 6;
    localparam int ST_CAPTURED    = 7;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic cellPortSelect;
        logic hostBusSelect;
        logic serial2Select;
        logic eepromAutoinitStrap;
    } strap_s;

    localparam strap_s STRAP_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic cellPortEnable;
        logic secondSerialEnable;
        logic cellPinsHighZ;
        logic serialPinsHighZ;
        logic hostPortEnable;
        logic pciEnable;
        logic pciStandaloneHighZ;
        logic thirdSerialEnable;
        logic eepromEnable;
        logic pciEepromLoad;
        logic timerEnable;
        logic firstSerialEnable;
        logic gpioLowerEnable;
    } periph_en_s;

    // Enables that all-low straps give.
    localparam periph_en_s PERIPH_EN_RESET = '{
        1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
        1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    // Capture sequencer states.
    typedef enum logic [1:0] {
        CAP_WAIT = 2'b01,
        CAP_DONE = 2'b10
    } cap_state_e;

endpackage

// ---- strap_capture.sv ----
// Purpose: Catches a strap vector once, at the first edge after reset release.
// Assumes: Straps are stable around reset release and synchronous to the clock.
// Notes:   The flops reset to constants; the pin levels are sampled clocked.

`timescale 1ns/1ns

module strap_capture
    import strap_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             resetn,
    // Strap levels and latched copy.
    input  wire logic [WIDTH-1:0] strapIn,
    output logic      [WIDTH-1:0] latched,
    output logic                  captured
);

    // ************************************************************
    // Checks
    // ************************************************************
    if (WIDTH < 1) begin : g_width_check
        $error("strap_capture needs at least one strap bit.");
    end

    cap_state_e state;
    wire        takeNow = (state == CAP_WAIT);

    // Sequencer: one sample after release, then hold until reset.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= CAP_WAIT;
        end else begin
            case (state)
                CAP_WAIT: state <= CAP_DONE;
                CAP_DONE: state <= CAP_DONE;
                default:  state <= CAP_WAIT;
            endcase
        end
    end

    // Latch register; frozen once taken.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            latched <= '0;
        end else if (takeNow) begin
            latched <= strapIn;
        end
    end

    assign captured = (state == CAP_DONE);

endmodule

// ---- peripheral_strap_pin_select.sv ----
// Purpose: Strap-driven selection of peripherals that share device pins.
// Assumes: Straps and select inputs are synchronous to core_clk.
// Notes:   Wishbone gives control of the upper GPIO pins and strap status.

`timescale 1ns/1ns

module peripheral_strap_pin_select
    import strap_pkg::*;
#(
    parameter int GPIO_UPPER_WIDTH = 7
) (
    // Clock and reset.
    input  wire logic                        core_clk,
    input  wire logic                        resetn,
    // Strap and select pins.
    input  wire logic                        cell_port_strap_pin,
    input  wire logic                        host_bus_strap_pin,
    input  wire logic                        serial2_select,
    input  wire logic                        eeprom_autoinit_pin,
    // Wishbone slave.
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    // Peripheral enables and pin tie-offs.
    output periph_en_s                       periphEnable,
    // Upper GPIO pin ownership.
    output logic      [GPIO_UPPER_WIDTH-1:0] gpioUpperFunction,
    output logic      [GPIO_UPPER_WIDTH-1:0] gpioUpperOe
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (GPIO_UPPER_WIDTH < 1 || GPIO_UPPER_WIDTH > 8) begin : g_gpio_check
        $error("GPIO_UPPER_WIDTH must lie between 1 and 8.");
    end

    // ************************************************************
    // Strap capture
    // ************************************************************
    strap_s strapPins;
    strap_s strapLatched;
    logic   captured;
    logic   serial2Live;

    // Pins gathered into one carrier for the capture block.
    assign strapPins = '{cell_port_strap_pin, host_bus_strap_pin,
                         serial2_select, eeprom_autoinit_pin};

    strap_capture #(
        .WIDTH ($bits(strap_s))
    ) u_capture (
        .core_clk (core_clk),
        .resetn   (resetn),
        .strapIn  (strapPins),
        .latched  (strapLatched),
        .captured (captured)
    );

    // Live copy of the serial2 select, kept after reset.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            serial2Live <= 1'b0;
        end else begin
            serial2Live <= serial2_select;
        end
    end

    // ************************************************************
    // Selection decode
    // ************************************************************
    periph_en_s next_periphEnable;
    wire        cellSel   = strapLatched.cellPortSelect;
    wire        pciSel    = strapLatched.hostBusSelect;
    wire        eepromSel = pciSel & ~serial2Live;
    wire        eeLoad    = pciSel & ~strapLatched.serial2Select
                            & strapLatched.eepromAutoinitStrap;

    // Cell port against second serial port.
    assign next_periphEnable.cellPortEnable     = cellSel;
    assign next_periphEnable.secondSerialEnable = ~cellSel;
    assign next_periphEnable.cellPinsHighZ      = ~cellSel;
    assign next_periphEnable.serialPinsHighZ    = cellSel;
    // Host port against PCI; the host select never changes after reset.
    assign next_periphEnable.hostPortEnable     = ~pciSel;
    assign next_periphEnable.pciEnable          = pciSel;
    assign next_periphEnable.pciStandaloneHighZ = ~pciSel;
    // Third serial port against the internal EEPROM.
    assign next_periphEnable.thirdSerialEnable  = ~eepromSel;
    assign next_periphEnable.eepromEnable       = eepromSel;
    assign next_periphEnable.pciEepromLoad      = eeLoad;
    // Peripherals that no strap can take away.
    assign next_periphEnable.timerEnable        = 1'b1;
    assign next_periphEnable.firstSerialEnable  = 1'b1;
    assign next_periphEnable.gpioLowerEnable    = 1'b1;

    // Registered enables; static once the straps are held, except third serial and EEPROM, which follow serial2Live.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            periphEnable <= PERIPH_EN_RESET;
        end else begin
            periphEnable <= next_periphEnable;
        end
    end

    // ************************************************************
    // Register bus
    // ************************************************************
    logic [31:0] ctrlReg;
    logic [31:0] next_rdata;
    logic [31:0] statusWord;
    wire         busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire         hitCtrl  = (wb_adr_i[7:2] == ADDR_CTRL[7:2]);
    wire         hitStat  = (wb_adr_i[7:2] == ADDR_STATUS[7:2]);
    wire         wrCtrl   = busReq & wb_we_i & hitCtrl;

    // Status word shows latched straps and the live selection.
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[ST_CELL_SEL]    = strapLatched.cellPortSelect;
        statusWord[ST_HOST_SEL]    = strapLatched.hostBusSelect;
        statusWord[ST_SERIAL2_SEL] = serial2Live;
        statusWord[ST_EEPROM_AUTOINIT_STRAP]        = strapLatched.eepromAutoinitStrap;
        statusWord[ST_EE_LOAD]     = periphEnable.pciEepromLoad;
        statusWord[ST_SER3_EN]     = periphEnable.thirdSerialEnable;
        statusWord[ST_EEPROM_EN]   = periphEnable.eepromEnable;
        statusWord[ST_CAPTURED]    = captured;
    end

    // Read mux; unmapped addresses read as zero.
    assign next_rdata = hitCtrl ? ctrlReg :
                        hitStat ? statusWord : 32'h0000_0000;

    // Acknowledge one cycle after the request; drops the cycle after.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= (busReq && !wb_we_i) ? next_rdata : 32'h0000_0000;
        end
    end

    // Control register, byte lanes 0 and 1 hold enable and direction.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrlReg <= CTRL_RESET;
        end else if (wrCtrl) begin
            if (wb_sel_i[0]) begin
                ctrlReg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                ctrlReg[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    // ************************************************************
    // Upper GPIO ownership
    // ************************************************************
    for (genvar i = 0; i < GPIO_UPPER_WIDTH; i++) begin : g_gpio
        wire pinEn  = ctrlReg[CTRL_EN_LSB + i];
        wire pinDir = ctrlReg[CTRL_DIR_LSB + i];
        wire fnNext = next_periphEnable.hostPortEnable & pinEn;

        // A pin is GPIO only with PCI off and its enable bit set.
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                gpioUpperFunction[i] <= 1'b0;
                gpioUpperOe[i]       <= 1'b0;
            end else begin
                gpioUpperFunction[i] <= fnNext;
                gpioUpperOe[i]       <= fnNext & pinDir;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // Straps are taken at the first edge after release.
    capture_once_a: assert property (
        resetn && !captured |=> captured && strapLatched == $past(strapPins))
        else $error("Straps not captured right after reset release.");

    // Latched straps never move once captured.
    latch_hold_a: assert property (
        captured |=> $stable(strapLatched))
        else $error("Latched straps changed during operation.");

    // Exclusive pairs never both on.
    periph_mutex_a: assert property (
        (periphEnable.cellPortEnable ^ periphEnable.secondSerialEnable)
        && (periphEnable.hostPortEnable ^ periphEnable.pciEnable)
        && (periphEnable.thirdSerialEnable ^ periphEnable.eepromEnable))
        else $error("Mutually exclusive peripherals enabled together.");

    // Cell port routing follows the latched select.
    cell_route_a: assert property (
        captured && !cellSel |=> periphEnable.secondSerialEnable
        && periphEnable.cellPinsHighZ && !periphEnable.serialPinsHighZ)
        else $error("Cell select low did not route to second serial.");

    cell_enable_a: assert property (
        captured && cellSel |=> periphEnable.cellPortEnable
        && periphEnable.serialPinsHighZ && !periphEnable.cellPinsHighZ)
        else $error("Cell select high did not route to cell port.");

    // Host port and PCI pins follow the latched host select.
    host_route_a: assert property (
        captured && !pciSel |=> periphEnable.hostPortEnable
        && periphEnable.pciStandaloneHighZ && !periphEnable.pciEnable)
        else $error("Host select low did not give the host port.");

    pci_route_a: assert property (
        captured && pciSel |=> periphEnable.pciEnable
        && !periphEnable.hostPortEnable && gpioUpperFunction == '0)
        else $error("Host select high did not give pins to PCI.");

    // GPIO drives only pins it owns, and owns them only with the host port on.
    gpio_gate_a: assert property (
        captured ##1 1'b1 |-> (gpioUpperOe & ~gpioUpperFunction) == '0
        && (gpioUpperFunction == '0 || periphEnable.hostPortEnable))
        else $error("Upper GPIO driven without ownership.");

    // Always-on peripherals.
    always_on_a: assert property (
        periphEnable.timerEnable && periphEnable.firstSerialEnable
        && periphEnable.gpioLowerEnable)
        else $error("Always-available peripheral was disabled.");

    // A serial2 rise re-enables the third serial port two edges later.
    sequence serial2_rise_s;
        captured && $rose(serial2_select);
    endsequence
    sequence serial3_back_s;
        periphEnable.thirdSerialEnable && !periphEnable.eepromEnable;
    endsequence
    serial2_live_a: assert property (
        serial2_rise_s |-> ##2 serial3_back_s)
        else $error("Serial2 select rise did not enable third serial.");

    // Third serial off only for PCI with serial2 low.
    serial3_sel_a: assert property (
        captured ##1 captured |-> periphEnable.thirdSerialEnable
        == !($past(pciSel) && !$past(serial2_select, 2)))
        else $error("Third serial enable does not match selects.");

    // EEPROM load only with PCI, serial2 low and strap high at reset.
    ee_load_a: assert property (
        captured ##1 1'b1 |-> periphEnable.pciEepromLoad == (
        strapLatched.hostBusSelect && !strapLatched.serial2Select
        && strapLatched.eepromAutoinitStrap))
        else $error("EEPROM auto-init does not match the straps.");

    ee_strap_a: assert property (
        !strapLatched.eepromAutoinitStrap |-> !periphEnable.pciEepromLoad)
        else $error("EEPROM load without the auto-init strap.");

    // Strap-held enables stay put while the device runs.
    strap_static_a: assert property (
        captured ##1 captured |=> $stable(periphEnable.pciEnable)
        && $stable(periphEnable.cellPortEnable)
        && $stable(periphEnable.pciEepromLoad))
        else $error("Strap-held enables moved without a reset.");

    // Each upper pin follows its own enable and direction bits.
    gpio_own_a: assert property (
        captured |=> gpioUpperFunction
        == ($past(ctrlReg[CTRL_EN_LSB +: GPIO_UPPER_WIDTH])
        & {GPIO_UPPER_WIDTH{!$past(pciSel)}})
        && gpioUpperOe == (gpioUpperFunction
        & $past(ctrlReg[CTRL_DIR_LSB +: GPIO_UPPER_WIDTH])))
        else $error("Upper GPIO does not follow its control bits.");

    // The bus acknowledge is a pulse of one cycle.
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus acknowledge stood for more than one cycle.");

    // Read data is zero whenever no acknowledge stands.
    rdata_idle_a: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("Read data shown without an acknowledge.");

endmodule

// ---- strap_board_model.sv ----
// Purpose: Board model that sets the strap resistors and the select driver.
// Assumes: The bench picks a board setup before each reset.
// Notes:   Every pin is always driven to a valid level, never left floating.

`timescale 1ns/1ns

module strap_board_model (
    // Board setup chosen by the bench.
    input  wire logic cellCfg,
    input  wire logic hostCfg,
    input  wire logic serial2Cfg,
    input  wire logic eeaiCfg,
    // Pins seen by the device.
    output logic      cell_port_strap_pin,
    output logic      host_bus_strap_pin,
    output logic      serial2_select,
    output logic      eeprom_autoinit_pin
);
    // ************************************************************
    // Strap resistors and select driver
    // ************************************************************
    // Resistor straps follow the setup; the bench never moves the host strap
    // while the device runs, so the host level stays valid and fixed.
    assign cell_port_strap_pin = cellCfg;
    assign host_bus_strap_pin  = hostCfg;
    assign eeprom_autoinit_pin = eeaiCfg;
    // The system drives the serial2 select at all times and may move it.
    assign serial2_select      = serial2Cfg;
endmodule

// ---- peripheral_strap_pin_select_tb_top.sv ----
// Purpose: Self-checking bench for the strap-driven pin selection block.
// Assumes: Wishbone answers one cycle after a request is taken.
// Notes:   Expected enables are derived here from the strap levels.

`timescale 1ns/1ns

module peripheral_strap_pin_select_tb_top import strap_pkg::*;;
    logic                 core_clk = 1'b0;
    logic                 resetn = 1'b0;
    logic                 cellCfg = 1'b0, hostCfg = 1'b0;
    logic                 serial2Cfg = 1'b0, eeaiCfg = 1'b0;
    logic                 wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0]           wbAdr = 8'h00;
    logic [3:0]           wbSel = 4'h0;
    logic [31:0]          wbWdat = 32'h0000_0000;
    wire logic            cellPin, hostPin, ser2Pin, eeaiPin;
    logic [31:0]          wbRdat;
    logic                 wbAck;
    periph_en_s           periphEnable;
    logic [6:0]           gpioFunc, gpioOe;
    int                   n_mismatch = 0;
    int                   compares = 0;

    // Clock at 250 MHz.
    always #2 core_clk = ~core_clk;

    // ************************************************************
    // Board model and device
    // ************************************************************
    strap_board_model i_board (.cellCfg(cellCfg), .hostCfg(hostCfg),
        .serial2Cfg(serial2Cfg), .eeaiCfg(eeaiCfg),
        .cell_port_strap_pin(cellPin), .host_bus_strap_pin(hostPin),
        .serial2_select(ser2Pin), .eeprom_autoinit_pin(eeaiPin));

    peripheral_strap_pin_select #(.GPIO_UPPER_WIDTH(7)) i_dut (
        .core_clk(core_clk), .resetn(resetn),
        .cell_port_strap_pin(cellPin), .host_bus_strap_pin(hostPin),
        .serial2_select(ser2Pin), .eeprom_autoinit_pin(eeaiPin),
        .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbWdat),
        .wb_dat_o(wbRdat), .wb_ack_o(wbAck), .periphEnable(periphEnable),
        .gpioUpperFunction(gpioFunc), .gpioUpperOe(gpioOe));

    // ************************************************************
    // Shared helpers
    // ************************************************************
    // Counts a comparison and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One classic Wishbone cycle; ack and read data are taken at the rising
    // edge that sees ack high, and only the watchdog ends a wait for it.
    task automatic wb_xfer(input logic we, input logic [7:0] adr,
                           input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hF;
        wbWdat <= wd;
        do begin
            @(posedge core_clk);
        end while (wbAck !== 1'b1);
        rd = wbRdat;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge core_clk);
        chk(wbAck, 1'b0, "ack one cycle");
        chk(wbRdat, 32'h0000_0000, "data after ack");
    endtask

    // Enables that the straps and the live serial2 level call for.
    function automatic logic [31:0] exp_en(input logic c, h, s0, sl, e);
        return {19'h0, c, !c, !c, c, !h, h, !h, !(h && !sl), h && !sl,
                h && !s0 && e, 1'b1, 1'b1, 1'b1};
    endfunction

    // Status word expected for the same setup.
    function automatic logic [31:0] exp_st(input logic c, h, s0, sl, e);
        return {24'h0, 1'b1, h && !sl, !(h && !sl), h && !s0 && e,
                e, sl, h, c};
    endfunction

    // Resets with a board setup, checks the reset state, then releases.
    task automatic do_reset(input logic c, h, s, e);
        @(posedge core_clk);
        resetn <= 1'b0;
        cellCfg <= c; hostCfg <= h; serial2Cfg <= s; eeaiCfg <= e;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        chk(periphEnable, PERIPH_EN_RESET, "reset enables");
        chk({gpioFunc, gpioOe}, 14'h0000, "reset gpio");
        @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Every strap setup gives its exclusive set of enables and status.
    task automatic run_strap_table();
        logic [31:0] rd;
        for (int i = 0; i < 16; i++) begin
            do_reset(i[3], i[2], i[1], i[0]);
            chk(periphEnable, exp_en(i[3], i[2], i[1], i[1], i[0]),
                "strap enables");
            wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
            chk(rd, exp_st(i[3], i[2], i[1], i[1], i[0]), "status");
        end
    endtask

    // Cell and auto-init strap moves after capture leave every enable where it was.
    task automatic run_late_straps();
        do_reset(1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge core_clk);
        cellCfg <= 1'b1; eeaiCfg <= 1'b1;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        chk(periphEnable, exp_en(0, 0, 0, 0, 0), "late straps");
    endtask

    // Serial2 rises and falls with no reset; the EEPROM load level stays.
    task automatic run_live_serial2();
        do_reset(1'b0, 1'b1, 1'b0, 1'b1);
        chk(periphEnable, exp_en(0, 1, 0, 0, 1), "eeprom mode");
        @(posedge core_clk);
        serial2Cfg <= 1'b1;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk(periphEnable, exp_en(0, 1, 0, 1, 1), "serial2 up");
        @(posedge core_clk);
        serial2Cfg <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk(periphEnable, exp_en(0, 1, 0, 0, 1), "serial2 down");
    endtask

    // Upper GPIO needs enable and direction bits, and only with host port.
    task automatic run_gpio(input logic h);
        logic [31:0] rd;
        do_reset(1'b0, h, 1'b0, 1'b0);
        wb_xfer(1'b1, ADDR_CTRL, 32'hFFFF_FFFF, rd);
        wb_xfer(1'b0, ADDR_CTRL, 32'h0000_0000, rd);
        chk(rd, 32'h0000_FFFF, "ctrl lanes");
        wb_xfer(1'b1, ADDR_CTRL, 32'h0000_553F, rd);
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk(gpioFunc, h ? 7'h00 : 7'h3F, "gpio function");
        chk(gpioOe, h ? 7'h00 : 7'h15, "gpio oe");
    endtask

    // Status writes change nothing; unmapped places change nothing and read zero.
    task automatic run_bus_map();
        logic [31:0] rd;
        do_reset(1'b1, 1'b0, 1'b1, 1'b0);
        wb_xfer(1'b1, ADDR_STATUS, 32'h0000_0000, rd);
        wb_xfer(1'b0, ADDR_STATUS, 32'h0000_0000, rd);
        chk(rd, exp_st(1, 0, 1, 1, 0), "status write");
        wb_xfer(1'b1, 8'h10, 32'hFFFF_FFFF, rd);
        wb_xfer(1'b0, 8'h10, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000, "unmapped");
        wb_xfer(1'b0, ADDR_CTRL, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000, "ctrl untouched");
    endtask

    // ************************************************************
    // Run control
    // ************************************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        run_strap_table();
        run_late_straps();
        run_live_serial2();
        run_gpio(1'b0);
        run_gpio(1'b1);
        run_bus_map();
        close_out();
    end

    // Watchdog well beyond the few hundred cycles the run needs.
    initial begin
        #200000;
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        close_out();
    end
endmodule
